// *** shared/crwc_params.svh ***
`ifndef CRWC_PARAMS_SVH
`define CRWC_PARAMS_SVH

// Register map
`define CRWC_ADDR_SETUP   8'h06
`define CRWC_SETUP_RST    16'h0000

// Field positions in channel_two_wave_setup
`define CRWC_B_CLR        15
`define CRWC_B_DEFER      14
`define CRWC_B_GROUP      13
`define CRWC_F_PHASE      12:11
`define CRWC_F_SHAPE      10:8
`define CRWC_B_LOG        7
`define CRWC_F_STEP       6:4
`define CRWC_F_LIN_IVL    3:0
`define CRWC_F_RISE       6:4
`define CRWC_F_FALL       3:1

// Field encodings
`define CRWC_PH_0         2'h0
`define CRWC_PH_120       2'h1
`define CRWC_PH_240       2'h2
`define CRWC_PH_90        2'h3
`define CRWC_SH_TRI       3'h0
`define CRWC_SH_SAW       3'h1
`define CRWC_SH_INV       3'h2
`define CRWC_SH_SINE      3'h4
`define CRWC_SH_OFF       3'h7
`define CRWC_IVL_NONE     4'h0

// Codes
`define CRWC_CODE_ZERO    10'h000
`define CRWC_CODE_MID     10'h200
`define CRWC_CODE_ONE     10'h001
`define CRWC_LOG_SHIFT    5
`define CRWC_THIRD_MUL    10'h155
`define CRWC_THIRD_SHIFT  10

// Linear code step, entry 7 first
`define CRWC_STEP_TABLE {6'h20, 6'h10, 6'h08, 6'h06, 6'h04, 6'h03, 6'h02, 6'h01}

// Step intervals in ns, highest code first
`define CRWC_LIN_NS_TABLE {23'h4E_3EF0, 23'h13_8FD0, 23'h13_8FD0, 23'h0B_2D90, 23'h06_6350, 23'h03_A660, \
    23'h02_1610, 23'h01_63F0, 23'h00_ED30, 23'h00_9E20, 23'h00_69A0, 23'h00_4650, 23'h00_2EE0, 23'h00_1F40, \
    23'h00_0FA0, 23'h00_0000}
`define CRWC_LOG_NS_TABLE {23'h4E_3EF0, 23'h13_8FD0, 23'h06_6350, 23'h02_1610, 23'h00_ED30, 23'h00_69A0, \
    23'h00_2EE0, 23'h00_0FA0}
`define CRWC_NS_PER_US    1000

`endif

// *** shared/crwc_pkg.sv ***
`default_nettype none

package crwc_pkg;
    typedef enum logic [1:0] {
        crwc_st_idle,
        crwc_st_slew,
        crwc_st_gen
    } crwc_state_t;
endpackage : crwc_pkg

`default_nettype wire

// *** rtl/crwc_channel_ramp.sv ***
// Notes on behaviour
// - Clear goes to zero or midscale by bit15
// - Bit14 low: written code applies at once
// - Bit14 high: hold code until load event
// - Broadcast writes accepted only when bit13 set
// - Phase field picks generator starting phase
// - Shape field picks waveform, 111 off, others invalid
// - Bit7 low selects linear stepping fields
// - Linear step size from bits 6-4 table
// - Linear step interval from bits 3-0 table
// - Interval 0000 jumps; invalid for generation
// - Bit7 high: geometric slew between bounds
// - Log rise grows by one thirty-second
// - Log fall shrinks by one thirty-second
// - Zero lower bound starts log slew at one
// - Log rise interval from bits 6-4
// - Log fall interval from bits 3-1
// - Setup register at 06h, resets zero
`timescale 1ns/100ps
`default_nettype none
`include "crwc_params.svh"

module crwc_channel_ramp #(
    parameter int unsigned CLK_MHZ = 250
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // Channel data
    input  wire logic        code_wr,
    input  wire logic        code_bcast,
    input  wire logic [9:0]  code_wdata,
    input  wire logic        load_trigger,
    input  wire logic        load_bit,
    input  wire logic        clear,
    // Generator control
    input  wire logic [9:0]  bound_low,
    input  wire logic [9:0]  bound_high,
    input  wire logic        gen_run,
    input  wire logic        margin_go,
    input  wire logic        margin_high_sel,
    // Status
    output logic      [9:0]  out_code,
    output logic             code_pending,
    output logic             gen_invalid,
    output logic             wave_active
);

    // Products of ns and MHz must stay inside 32 bits
    if (CLK_MHZ < 1 || CLK_MHZ > 800) begin : g_bad_clk
        $error("CLK_MHZ out of range");
    end

    localparam logic [47:0]  STEP_TAB = `CRWC_STEP_TABLE;
    localparam logic [367:0] LIN_NS   = `CRWC_LIN_NS_TABLE;
    localparam logic [183:0] LOG_NS   = `CRWC_LOG_NS_TABLE;

    logic [15:0] setup_r, setup_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [9:0]  code_r, code_nxt;
    logic [9:0]  pend_r, pend_nxt;
    logic [9:0]  tgt_r, tgt_nxt;
    logic        pend_v_r, pend_v_nxt;
    logic        inv_r, inv_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic [2:0]  ld_sync_r, ld_sync_nxt;
    logic        ld_lvl_r, ld_lvl_nxt;
    crwc_pkg::crwc_state_t st_r, st_nxt;

    logic        clr_sel, defer, group_write_accept, log_mode;
    logic [1:0]  phase_sel;
    logic [2:0]  waveform_shape_select;
    logic [5:0]  step_sz;
    logic [22:0] ivl_ns;
    logic [31:0] ivl_cyc;
    logic        up, acc, load_evt, load_fall, gen_ok, jump, quiet, step_take;
    logic [9:0]  log_inc, start_low, lin_up, lin_dn, log_up, log_dn, step_code;
    logic [10:0] sum_lin, sum_log;
    logic [18:0] third_prod;
    logic [9:0]  span, third;

    assign clr_sel               = setup_r[`CRWC_B_CLR];
    assign defer                 = setup_r[`CRWC_B_DEFER];
    assign group_write_accept    = setup_r[`CRWC_B_GROUP];
    assign phase_sel             = setup_r[`CRWC_F_PHASE];
    assign waveform_shape_select = setup_r[`CRWC_F_SHAPE];
    assign log_mode              = setup_r[`CRWC_B_LOG];

    // Pin synchroniser: a change counts once stages two and three agree
    always_comb begin
        ld_sync_nxt = {ld_sync_r[1:0], load_trigger};
        ld_lvl_nxt  = (ld_sync_r[1] == ld_sync_r[2]) ? ld_sync_r[1] : ld_lvl_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ld_sync_r <= 3'h7;
            ld_lvl_r  <= 1'b1;
        end else if (ce) begin
            ld_sync_r <= ld_sync_nxt;
            ld_lvl_r  <= ld_lvl_nxt;
        end
    end

    assign load_fall = ld_lvl_r && (ld_sync_r[2:1] == 2'h0);
    assign load_evt  = load_fall || load_bit;
    assign acc       = code_wr || (code_bcast && group_write_accept);
    assign quiet     = !clear && !acc && !(load_evt && pend_v_r);

    // Slew arithmetic
    always_comb begin
        up      = tgt_r > code_r;
        step_sz = STEP_TAB[6*setup_r[`CRWC_F_STEP] +: 6];
        if (!log_mode) begin
            ivl_ns = LIN_NS[23*setup_r[`CRWC_F_LIN_IVL] +: 23];
        end else if (up) begin
            ivl_ns = LOG_NS[23*setup_r[`CRWC_F_RISE] +: 23];
        end else begin
            ivl_ns = LOG_NS[23*setup_r[`CRWC_F_FALL] +: 23];
        end
        ivl_cyc = 32'(({9'h000, ivl_ns} * CLK_MHZ) / `CRWC_NS_PER_US);
        if (ivl_cyc == 32'h0000_0000) begin
            ivl_cyc = 32'h0000_0001;
        end
        // Geometric step, never less than one code so the slew always advances
        log_inc = code_r >> `CRWC_LOG_SHIFT;
        if (log_inc == `CRWC_CODE_ZERO) begin
            log_inc = `CRWC_CODE_ONE;
        end
        sum_lin = {1'b0, code_r} + {5'h00, step_sz};
        lin_up  = (sum_lin >= {1'b0, tgt_r}) ? tgt_r : sum_lin[9:0];
        lin_dn  = ({4'h0, step_sz} >= code_r - tgt_r) ? tgt_r : code_r - {4'h0, step_sz};
        sum_log = {1'b0, code_r} + {1'b0, log_inc};
        log_up  = (sum_log >= {1'b0, tgt_r}) ? tgt_r : sum_log[9:0];
        log_dn  = (log_inc >= code_r - tgt_r) ? tgt_r : code_r - log_inc;
        if (log_mode) begin
            step_code = up ? log_up : log_dn;
        end else begin
            step_code = up ? lin_up : lin_dn;
        end
        start_low  = (log_mode && bound_low == `CRWC_CODE_ZERO) ? `CRWC_CODE_ONE : bound_low;
        span       = bound_high - start_low;
        third_prod = span * `CRWC_THIRD_MUL;
        third      = {1'b0, third_prod[18:`CRWC_THIRD_SHIFT]};
    end

    assign jump   = !log_mode && setup_r[`CRWC_F_LIN_IVL] == `CRWC_IVL_NONE;
    assign gen_ok = gen_run && !jump && (waveform_shape_select == `CRWC_SH_TRI ||
                    waveform_shape_select == `CRWC_SH_SAW || waveform_shape_select == `CRWC_SH_INV ||
                    waveform_shape_select == `CRWC_SH_SINE);
    assign step_take = st_r != crwc_pkg::crwc_st_idle && (st_r != crwc_pkg::crwc_st_gen || gen_ok) &&
                       code_r != tgt_r && tmr_r <= 32'h0000_0001;

    // Register file, data path and slew engine
    always_comb begin
        setup_nxt  = setup_r;
        rdata_nxt  = 16'h0000;
        code_nxt   = code_r;
        pend_nxt   = pend_r;
        pend_v_nxt = pend_v_r;
        tgt_nxt    = tgt_r;
        tmr_nxt    = tmr_r;
        st_nxt     = st_r;
        inv_nxt    = gen_run && !gen_ok && waveform_shape_select != `CRWC_SH_OFF;
        if (reg_wr && reg_addr == `CRWC_ADDR_SETUP) begin
            setup_nxt = reg_wdata;
        end
        if (reg_rd && reg_addr == `CRWC_ADDR_SETUP) begin
            rdata_nxt = setup_r;
        end
        case (st_r)
            crwc_pkg::crwc_st_idle: begin
                if (gen_ok) begin
                    st_nxt  = crwc_pkg::crwc_st_gen;
                    tmr_nxt = ivl_cyc;
                    // Phase as a fraction of a triangle period
                    case (phase_sel)
                        `CRWC_PH_0: begin
                            code_nxt = start_low;
                            tgt_nxt  = bound_high;
                        end
                        `CRWC_PH_120: begin
                            code_nxt = bound_high - third;
                            tgt_nxt  = bound_high;
                        end
                        `CRWC_PH_240: begin
                            code_nxt = bound_high - third;
                            tgt_nxt  = start_low;
                        end
                        default: begin
                            code_nxt = start_low + (span >> 1);
                            tgt_nxt  = bound_high;
                        end
                    endcase
                end else if (margin_go && waveform_shape_select == `CRWC_SH_OFF) begin
                    tgt_nxt = margin_high_sel ? bound_high : start_low;
                    if (jump) begin
                        code_nxt = tgt_nxt;
                    end else begin
                        st_nxt  = crwc_pkg::crwc_st_slew;
                        tmr_nxt = ivl_cyc;
                    end
                end
            end
            crwc_pkg::crwc_st_slew,
            crwc_pkg::crwc_st_gen: begin
                if (st_r == crwc_pkg::crwc_st_gen && !gen_ok) begin
                    st_nxt = crwc_pkg::crwc_st_idle;
                end else if (code_r == tgt_r) begin
                    tmr_nxt = ivl_cyc;
                    if (st_r == crwc_pkg::crwc_st_slew) begin
                        st_nxt = crwc_pkg::crwc_st_idle;
                    end else if (waveform_shape_select == `CRWC_SH_SAW) begin
                        code_nxt = start_low;
                        tgt_nxt  = bound_high;
                    end else if (waveform_shape_select == `CRWC_SH_INV) begin
                        code_nxt = bound_high;
                        tgt_nxt  = start_low;
                    end else begin
                        tgt_nxt = (tgt_r == bound_high) ? start_low : bound_high;
                    end
                end else if (step_take) begin
                    code_nxt = step_code;
                    tmr_nxt  = ivl_cyc;
                end else begin
                    tmr_nxt = tmr_r - 32'h0000_0001;
                end
            end
            default: begin
                st_nxt = crwc_pkg::crwc_st_idle;
            end
        endcase
        if (load_evt && pend_v_r) begin
            code_nxt   = pend_r;
            pend_v_nxt = 1'b0;
        end
        // A deferred write landing with a load is kept for the next load
        if (acc) begin
            if (defer) begin
                pend_nxt   = code_wdata;
                pend_v_nxt = 1'b1;
            end else begin
                code_nxt = code_wdata;
            end
        end
        if (clear) begin
            code_nxt = clr_sel ? `CRWC_CODE_MID : `CRWC_CODE_ZERO;
            st_nxt   = crwc_pkg::crwc_st_idle;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            setup_r  <= `CRWC_SETUP_RST;
            rdata_r  <= 16'h0000;
            code_r   <= `CRWC_CODE_ZERO;
            pend_r   <= `CRWC_CODE_ZERO;
            pend_v_r <= 1'b0;
            tgt_r    <= `CRWC_CODE_ZERO;
            tmr_r    <= 32'h0000_0000;
            st_r     <= crwc_pkg::crwc_st_idle;
            inv_r    <= 1'b0;
        end else if (ce) begin
            setup_r  <= setup_nxt;
            rdata_r  <= rdata_nxt;
            code_r   <= code_nxt;
            pend_r   <= pend_nxt;
            pend_v_r <= pend_v_nxt;
            tgt_r    <= tgt_nxt;
            tmr_r    <= tmr_nxt;
            st_r     <= st_nxt;
            inv_r    <= inv_nxt;
        end
    end

    assign reg_rdata    = rdata_r;
    assign out_code     = code_r;
    assign code_pending = pend_v_r;
    assign gen_invalid  = inv_r;
    assign wave_active  = st_r != crwc_pkg::crwc_st_idle;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_defer_write;
        ce && acc && defer && !clear;
    endsequence

    sequence s_load_apply;
        ce && load_evt && pend_v_r && !clear && !acc;
    endsequence

    a_clear_zero: assert property (ce && clear && !clr_sel |=> out_code == `CRWC_CODE_ZERO)
        else $error("clear did not reach zero scale");
    a_clear_mid: assert property (ce && clear && clr_sel |=> out_code == `CRWC_CODE_MID)
        else $error("clear did not reach midscale");
    a_write_now: assert property (ce && acc && !defer && !clear |=> out_code == $past(code_wdata))
        else $error("immediate write not applied");
    a_defer_load: assert property (s_defer_write ##[1:8] s_load_apply
        |=> out_code == $past(pend_r) && !code_pending)
        else $error("deferred code not moved on load");
    a_defer_hold: assert property (s_defer_write |=> code_pending && out_code != $past(code_wdata) ||
        $past(out_code) == $past(code_wdata) || $past(st_r) != crwc_pkg::crwc_st_idle)
        else $error("deferred code reached output early");
    a_bcast_ignore: assert property (ce && code_bcast && !code_wr && !group_write_accept && !clear
        && !load_evt && st_r == crwc_pkg::crwc_st_idle && !gen_ok && !margin_go
        |=> $stable(out_code) && $stable(code_pending))
        else $error("broadcast accepted while disabled");
    a_phase_zero: assert property (ce && quiet && st_r == crwc_pkg::crwc_st_idle && gen_ok
        && phase_sel == `CRWC_PH_0 |=> out_code == $past(start_low) && tgt_r == $past(bound_high))
        else $error("zero phase start wrong");
    // Settings may go invalid at any edge; the engine must then drop out of generation
    a_gen_valid: assert property (st_r == crwc_pkg::crwc_st_gen && ce && quiet && !gen_ok |=> !wave_active)
        else $error("generator ran with invalid settings");
    a_lin_step: assert property (ce && quiet && step_take && !log_mode && up
        |=> out_code > $past(out_code) && out_code - $past(out_code) <= $past(step_sz))
        else $error("linear step out of range");
    a_log_rise: assert property (ce && quiet && step_take && log_mode && up
        |=> out_code - $past(out_code) <= ($past(out_code) >> 5) + 10'h001)
        else $error("log rise step too large");
    a_log_fall: assert property (ce && quiet && step_take && log_mode && !up
        |=> $past(out_code) - out_code <= ($past(out_code) >> 5) + 10'h001)
        else $error("log fall step too large");
    a_no_slew_jump: assert property (ce && quiet && st_r == crwc_pkg::crwc_st_idle && margin_go && jump
        && waveform_shape_select == `CRWC_SH_OFF |=> out_code == tgt_r && !wave_active)
        else $error("no-slew margin did not jump");
    a_reset_zero: assert property (disable iff (1'b0) rst |=> setup_r == `CRWC_SETUP_RST)
        else $error("setup register not reset");

endmodule : crwc_channel_ramp

`default_nettype wire

// *** dv/crwc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module crwc_host_model (
    // Clock and read data
    input  wire logic        clk,
    input  wire logic [15:0] reg_rdata,
    // Register strobes
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [7:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    // Load pin, idle high
    output logic             load_trigger
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        load_trigger = 1'b1;
    end

    // Callers enter just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
        // One idle edge so a following call never re-raises the strobe at once
        @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
        @(posedge clk);
        #1;
    endtask : rd

    // Held low long enough for the synchroniser to see it
    task automatic pin_fall();
        load_trigger = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        load_trigger = 1'b1;
    endtask : pin_fall
endmodule : crwc_host_model

`default_nettype wire

// *** dv/channel_ramp_waveform_config_test.sv ***
`timescale 1ns/100ps
`default_nettype none

module channel_ramp_waveform_config_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic reg_wr, reg_rd, load_trigger;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d, seed;
    logic code_wr = 1'b0, code_bcast = 1'b0, load_bit = 1'b0, clear = 1'b0;
    logic gen_run = 1'b0, margin_go = 1'b0, margin_high_sel = 1'b0;
    logic [9:0] code_wdata = 10'h000, bound_low = 10'h000, bound_high = 10'h000, out_code;
    logic code_pending, gen_invalid, wave_active;
    int n_mismatch = 0;
    int compares = 0;
    int m_out, n;
    int step_tbl[8] = '{1, 2, 3, 4, 6, 8, 16, 32};

    always #2 clk = ~clk;

    crwc_channel_ramp #(.CLK_MHZ(1)) crwc_channel_ramp_inst (
        .clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .code_wr(code_wr), .code_bcast(code_bcast),
        .code_wdata(code_wdata), .load_trigger(load_trigger), .load_bit(load_bit), .clear(clear),
        .bound_low(bound_low), .bound_high(bound_high), .gen_run(gen_run), .margin_go(margin_go),
        .margin_high_sel(margin_high_sel), .out_code(out_code), .code_pending(code_pending),
        .gen_invalid(gen_invalid), .wave_active(wave_active)
    );

    crwc_host_model crwc_host_model_inst (
        .clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .load_trigger(load_trigger)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask : pulse

    task automatic cw(input logic bc, input logic [9:0] v);
        code_wdata = v;
        code_wr = !bc;
        code_bcast = bc;
        tick(1);
        code_wr = 1'b0;
        code_bcast = 1'b0;
        tick(1);
    endtask : cw

    // Clear also parks the engine between scenarios
    task automatic park();
        gen_run = 1'b0;
        crwc_host_model_inst.wr(8'h06, 16'h0000);
        pulse(clear);
        m_out = 0;
    endtask : park

    task automatic wait_chg(output int k);
        logic [9:0] o;
        o = out_code;
        k = 0;
        while (out_code === o && k < 6000) begin
            tick(1);
            k++;
        end
    endtask : wait_chg

    task automatic margin(input logic hi);
        margin_high_sel = hi;
        pulse(margin_go);
    endtask : margin

    initial begin
        #120000;
        n_mismatch++;
        summarize();
    end

    initial begin
        seed = 16'hD5E1;
        m_out = 0;
        tick(16);
        rst = 1'b0;
        tick(4);
        crwc_host_model_inst.rd(8'h06, d);
        chk(d, 16'h0000);
        crwc_host_model_inst.rd(8'h07, d);
        chk(d, 16'h0000);
        repeat (4) begin
            seed = lfsr(seed);
            crwc_host_model_inst.wr(8'h06, seed);
            crwc_host_model_inst.rd(8'h06, d);
            chk(d, seed);
        end
        ce = 1'b0;
        crwc_host_model_inst.wr(8'h06, ~seed);
        ce = 1'b1;
        crwc_host_model_inst.rd(8'h06, d);
        chk(d, seed);
        park();
        repeat (3) begin
            seed = lfsr(seed);
            cw(1'b0, seed[9:0]);
            m_out = seed[9:0];
            chk(out_code, m_out[9:0]);
        end
        cw(1'b1, ~seed[9:0]);
        chk(out_code, m_out[9:0]);
        crwc_host_model_inst.wr(8'h06, 16'h2000);
        cw(1'b1, 10'h2A5);
        chk(out_code, 10'h2A5);
        m_out = 10'h2A5;
        crwc_host_model_inst.wr(8'h06, 16'h4000);
        cw(1'b0, 10'h155);
        chk(out_code, m_out[9:0]);
        chk(code_pending, 1'b1);
        pulse(load_bit);
        chk(out_code, 10'h155);
        chk(code_pending, 1'b0);
        cw(1'b0, 10'h0F0);
        crwc_host_model_inst.pin_fall();
        tick(2);
        chk(out_code, 10'h0F0);
        for (int b = 0; b < 2; b++) begin
            crwc_host_model_inst.wr(8'h06, {b[0], 15'h0000});
            pulse(clear);
            chk(out_code, b ? 10'h200 : 10'h000);
        end
        park();
        bound_low = 10'd40;
        bound_high = 10'd240;
        for (int s = 0; s < 7; s++) begin
            crwc_host_model_inst.wr(8'h06, {5'h00, s[2:0], 8'h0F});
            gen_run = 1'b1;
            tick(3);
            chk(gen_invalid, (s == 3 || s == 5 || s == 6));
            park();
        end
        crwc_host_model_inst.wr(8'h06, 16'h0000);
        gen_run = 1'b1;
        tick(3);
        chk(gen_invalid, 1'b1);
        park();
        // Span 200: a third is 66, so 120 and 240 start at 174
        for (int p = 0; p < 4; p++) begin
            crwc_host_model_inst.wr(8'h06, {3'h0, p[1:0], 3'h0, 8'h0F});
            gen_run = 1'b1;
            tick(3);
            chk(out_code, (p == 0) ? 10'd40 : ((p == 3) ? 10'd140 : 10'd174));
            chk(wave_active, 1'b1);
            park();
        end
        bound_low = 10'd0;
        bound_high = 10'd1000;
        for (int k = 0; k < 8; k++) begin
            crwc_host_model_inst.wr(8'h06, {5'h00, 3'h7, 1'b0, k[2:0], 4'h1});
            margin(1'b1);
            wait_chg(n);
            m_out = step_tbl[k];
            chk(out_code, m_out[9:0]);
            wait_chg(n);
            chk(n[15:0], 16'h0004);
            park();
        end
        crwc_host_model_inst.wr(8'h06, {5'h00, 3'h7, 8'h00});
        margin(1'b1);
        tick(2);
        chk(out_code, 10'd1000);
        park();
        // Log mode, bit 0 set to show it is ignored
        crwc_host_model_inst.wr(8'h06, {5'h00, 3'h7, 1'b1, 3'h1, 3'h2, 1'b1});
        cw(1'b0, 10'd64);
        margin(1'b1);
        wait_chg(n);
        chk(out_code, 10'd66);
        wait_chg(n);
        chk(n[15:0], 16'h000C);
        n = 0;
        while (wave_active !== 1'b0 && n < 6000) begin
            tick(1);
            n++;
        end
        chk(out_code, 10'd1000);
        margin(1'b0);
        wait_chg(n);
        chk(out_code, 10'd969);
        wait_chg(n);
        chk(n[15:0], 16'h001B);
        n = 0;
        while (wave_active !== 1'b0 && n < 6000) begin
            tick(1);
            n++;
        end
        chk(out_code, 10'd1);
        summarize();
    end
endmodule : channel_ramp_waveform_config_test

`default_nettype wire
